// ==== inc/lsci_cfg.svh ====
// Constants of the linear sensor command interpreter.
// Assumes one system clock; sensor clock and data arrive as pins.
//
// Functional notes
// [RQ1] Thirty low clocks reinitialize command tracking.
// [RQ2] Controller sends break first after power-up.
// [RQ3] Main reset clears readout, integration, samples.
// [RQ4] Output defined thirty clocks after reset.
// [RQ5] Start integration after 22-clock pixel reset.
// [RQ6] Sample holds values, integrators back to reset.
// [RQ7] Pixel word: start 0, LSB first, stop 1.
// [RQ8] Pixels sent in order 0 to 101.
// [RQ9] First pixel word 44 clocks after command.
// [RQ10] Abort stops readout, integration, clears samples.
// [RQ11] Code 0x12 samples then reads out.
// [RQ12] Code 0x16 samples, reads, restarts integration.
// [RQ13] Register write: command byte then data.
// [RQ14] Register read starts 4 clocks after command.
// [RQ15] Controller gives 5 clocks after each command.
// [RQ16] Controller holds input high 10 clocks first.
// [RQ17] Mode 0x10 sleeps analog, 0x00 wakes.
// [RQ18] Controller writes only 0x00 or 0x10 mode.
// [RQ19] Controller waits 1 ms before imaging; the bench issues start with no such wait.
// [RQ20] Readout completes before next sample command.
// [RQ21] Pixel reset takes 22 clocks, link stays usable.
// [RQ22] Controller programs gain and offset first.
// [RQ23] Sample input on rise, change output on fall.
// [RQ24] Receive and transmit run independently.
// [RQ25] Zone offsets, gains and mode register map.
// [RQ26] Unknown command bytes are ignored.
`ifndef LSCI_CFG_SVH
`define LSCI_CFG_SVH
`define LSCI_CMD_RESET  8'h1b
`define LSCI_CMD_START  8'h08
`define LSCI_CMD_SAMPLE 8'h10
`define LSCI_CMD_READ   8'h02
`define LSCI_CMD_ABORT  8'h19
`define LSCI_CMD_RDHOLD 8'h12
`define LSCI_CMD_RDHNS  8'h16
`define LSCI_OP_WRITE   3'h2
`define LSCI_OP_READ    3'h3
`define LSCI_BREAK_CLKS 5'h1e
`define LSCI_PRST_CLKS  5'h16
`define LSCI_PIX_DELAY  6'h2c
`define LSCI_REG_DELAY  6'h04
`define LSCI_PIX_LAST   7'h65
`define LSCI_FRAME_BITS 4'h9
`define LSCI_ADR_OFF0   5'h00
`define LSCI_ADR_GAIN0  5'h01
`define LSCI_ADR_OFF1   5'h02
`define LSCI_ADR_GAIN1  5'h03
`define LSCI_ADR_OFF2   5'h04
`define LSCI_ADR_GAIN2  5'h05
`define LSCI_ADR_MODE   5'h1f
`define LSCI_SLEEP_BIT  4
`endif

// ==== inc/lsci_pkg.sv ====
// Types of the linear sensor command interpreter.
// Assumes lsci_cfg.svh for all numeric constants.
package lsci_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_WAITHI} lsci_rx_e;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} lsci_tx_e;
  typedef struct packed {
    logic       sclk_m;
    logic       sclk_s;
    logic       sclk_d;
    logic       sin_m;
    logic       sin_s;
    lsci_rx_e   rx;
    logic [2:0] rx_bits;
    logic [7:0] rx_sh;
    logic [4:0] zeros;
    logic       wr_pend;
    logic [4:0] wr_addr;
    logic [4:0] rd_addr;
    logic       integ;
    logic       held;
    logic [4:0] prst;
    lsci_tx_e   tx;
    logic [5:0] wcnt;
    logic [9:0] tx_sh;
    logic [3:0] tx_bits;
    logic       pix_mode;
    logic [6:0] pix_idx;
    logic       sout;
    logic [7:0] off0;
    logic [7:0] off1;
    logic [7:0] off2;
    logic [4:0] gn0;
    logic [4:0] gn1;
    logic [4:0] gn2;
    logic [7:0] mode;
  } lsci_state_s;
endpackage

// ==== hdl/lsci_top.sv ====
// Command interpreter of a 102-pixel linear sensor.
// Assumes the serial clock and data are asynchronous pins and the
// pixel converter presents a code for o_pixel_idx on i_pixel_code.
`timescale 1ns/10ps
`include "lsci_cfg.svh"

module lsci_top (
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_sclk,
  input  wire logic        i_serial_in,
  input  wire logic [7:0]  i_pixel_code,
  output logic             o_serial_out,
  output logic             o_integrating,
  output logic             o_held_valid,
  output logic             o_pixel_reset,
  output logic [6:0]       o_pixel_idx,
  output logic [23:0]      o_offsets,
  output logic [14:0]      o_gains,
  output logic             o_sleep
);

  lsci_pkg::lsci_state_s r;
  lsci_pkg::lsci_state_s n;
  logic                  rise;
  logic                  fall;
  logic                  byte_done;
  logic                  brk;
  logic                  exec;
  logic                  do_load;
  logic [7:0]            rx_byte;
  logic [7:0]            rd_val;
  logic [7:0]            ld_data;

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  always_comb begin
    n         = r;
    rise      = r.sclk_s & ~r.sclk_d;
    fall      = ~r.sclk_s & r.sclk_d;
    byte_done = 1'b0;
    brk       = 1'b0;
    exec      = 1'b0;
    do_load   = 1'b0;
    rx_byte   = {r.sin_s, r.rx_sh[7:1]};
    n.sclk_m  = i_sclk;
    n.sclk_s  = r.sclk_m;
    n.sclk_d  = r.sclk_s;
    n.sin_m   = i_serial_in;
    n.sin_s   = r.sin_m;
    unique case (r.rd_addr)
      `LSCI_ADR_OFF0:  rd_val = r.off0;
      `LSCI_ADR_GAIN0: rd_val = {3'h0, r.gn0};
      `LSCI_ADR_OFF1:  rd_val = r.off1;
      `LSCI_ADR_GAIN1: rd_val = {3'h0, r.gn1};
      `LSCI_ADR_OFF2:  rd_val = r.off2;
      `LSCI_ADR_GAIN2: rd_val = {3'h0, r.gn2};
      `LSCI_ADR_MODE:  rd_val = r.mode;
      default:         rd_val = 8'h00;
    endcase
    ld_data = r.pix_mode ? i_pixel_code : rd_val;

    // [RQ23] Receiver samples on rise.
    if (rise) begin
      if (r.sin_s) begin
        n.zeros = 5'h00;
      end else if (r.zeros != `LSCI_BREAK_CLKS) begin
        n.zeros = r.zeros + 5'h01;
      end
      unique case (r.rx)
        lsci_pkg::RX_IDLE: begin
          if (!r.sin_s) begin
            n.rx      = lsci_pkg::RX_DATA;
            n.rx_bits = 3'h0;
          end
        end
        lsci_pkg::RX_DATA: begin
          n.rx_sh   = rx_byte;
          n.rx_bits = r.rx_bits + 3'h1;
          if (r.rx_bits == 3'h7) begin
            byte_done = 1'b1;
            n.rx      = lsci_pkg::RX_IDLE;
          end
        end
        lsci_pkg::RX_WAITHI: begin
          if (r.sin_s) begin
            n.rx = lsci_pkg::RX_IDLE;
          end
        end
      endcase
      // [RQ1] Break reinitializes tracking.
      if (!r.sin_s && r.zeros == `LSCI_BREAK_CLKS - 5'h01) begin
        brk       = 1'b1;
        byte_done = 1'b0;
        n.rx      = lsci_pkg::RX_WAITHI;
        n.wr_pend = 1'b0;
      end
      // [RQ21] Pixel reset countdown.
      if (r.prst != 5'h00) begin
        n.prst = r.prst - 5'h01;
        if (r.prst == 5'h01) begin
          n.integ = 1'b1;
        end
      end
    end

    // [RQ13] Data byte stores register.
    if (byte_done && r.wr_pend) begin
      n.wr_pend = 1'b0;
      unique case (r.wr_addr)
        `LSCI_ADR_OFF0:  n.off0 = rx_byte;
        `LSCI_ADR_GAIN0: n.gn0 = rx_byte[4:0];
        `LSCI_ADR_OFF1:  n.off1 = rx_byte;
        `LSCI_ADR_GAIN1: n.gn1 = rx_byte[4:0];
        `LSCI_ADR_OFF2:  n.off2 = rx_byte;
        `LSCI_ADR_GAIN2: n.gn2 = rx_byte[4:0];
        // [RQ17] Mode register holds sleep.
        `LSCI_ADR_MODE:  n.mode = rx_byte;
        default: ;
      endcase
    end else if (byte_done) begin
      exec = 1'b1;
    end

    // [RQ26] Unknown bytes fall through.
    if (exec) begin
      // [RQ3] Main reset and [RQ10] abort.
      if (rx_byte == `LSCI_CMD_RESET || rx_byte == `LSCI_CMD_ABORT) begin
        n.integ    = 1'b0;
        n.held     = 1'b0;
        n.prst     = 5'h00;
        n.tx       = lsci_pkg::TX_IDLE;
        n.sout     = 1'b1;
        n.pix_mode = 1'b0;
      end
      // [RQ6] Sample, also [RQ11] and [RQ12].
      if (rx_byte == `LSCI_CMD_SAMPLE || rx_byte == `LSCI_CMD_RDHOLD ||
          rx_byte == `LSCI_CMD_RDHNS) begin
        n.held  = 1'b1;
        n.integ = 1'b0;
      end
      // [RQ9] Readout latency start.
      if (rx_byte == `LSCI_CMD_READ || rx_byte == `LSCI_CMD_RDHOLD ||
          rx_byte == `LSCI_CMD_RDHNS) begin
        n.tx       = lsci_pkg::TX_WAIT;
        n.wcnt     = `LSCI_PIX_DELAY;
        n.pix_mode = 1'b1;
        n.pix_idx  = 7'h00;
      end
      // [RQ5] Start via pixel reset.
      if (rx_byte == `LSCI_CMD_START || rx_byte == `LSCI_CMD_RDHNS) begin
        n.prst  = `LSCI_PRST_CLKS;
        n.integ = 1'b0;
      end
      if (rx_byte[7:5] == `LSCI_OP_WRITE) begin
        n.wr_pend = 1'b1;
        n.wr_addr = rx_byte[4:0];
      end
      // [RQ14] Register read latency.
      if (rx_byte[7:5] == `LSCI_OP_READ) begin
        n.rd_addr  = rx_byte[4:0];
        n.tx       = lsci_pkg::TX_WAIT;
        n.wcnt     = `LSCI_REG_DELAY;
        n.pix_mode = 1'b0;
      end
    end

    // [RQ24] Transmitter runs on falls.
    if (fall) begin
      unique case (r.tx)
        lsci_pkg::TX_IDLE: n.sout = 1'b1;
        lsci_pkg::TX_WAIT: begin
          if (r.wcnt == 6'h01) begin
            do_load = 1'b1;
          end else begin
            n.wcnt = r.wcnt - 6'h01;
          end
        end
        lsci_pkg::TX_SEND: begin
          if (r.tx_bits != 4'h0) begin
            n.tx_sh   = {1'b1, r.tx_sh[9:1]};
            n.sout    = r.tx_sh[1];
            n.tx_bits = r.tx_bits - 4'h1;
          end else if (r.pix_mode) begin
            do_load = 1'b1;
          end else begin
            n.tx   = lsci_pkg::TX_IDLE;
            n.sout = 1'b1;
          end
        end
        default: n.tx = lsci_pkg::TX_IDLE;
      endcase
    end

    // [RQ7] Frame start, data, stop.
    if (do_load) begin
      n.tx      = lsci_pkg::TX_SEND;
      n.tx_sh   = {1'b1, ld_data, 1'b0};
      n.sout    = 1'b0;
      n.tx_bits = `LSCI_FRAME_BITS;
      // [RQ8] Ascending pixel order.
      if (r.pix_mode) begin
        if (r.pix_idx == `LSCI_PIX_LAST) begin
          n.pix_mode = 1'b0;
        end else begin
          n.pix_idx = r.pix_idx + 7'h01;
        end
      end
    end

    // [RQ4] Output idles high.
    if (i_reset) begin
      n      = '0;
      n.sout = 1'b1;
    end
  end

  // --------------------------------------------------------------
  // State register and outputs
  // --------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    r <= n;
  end

  assign o_serial_out  = r.sout;
  assign o_integrating = r.integ;
  assign o_held_valid  = r.held;
  assign o_pixel_reset = (r.prst != 5'h00);
  assign o_pixel_idx   = r.pix_idx;
  // [RQ25] Zone registers to analog.
  assign o_offsets     = {r.off2, r.off1, r.off0};
  assign o_gains       = {r.gn2, r.gn1, r.gn0};
  assign o_sleep       = r.mode[`LSCI_SLEEP_BIT];

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  sequence s_cmd(logic [7:0] c);
    exec && rx_byte == c;
  endsequence

  AST_BREAK: assert property (brk |=> r.rx == lsci_pkg::RX_WAITHI && !r.wr_pend) // [RQ1]
    else $error("break did not reinitialize receiver");
  AST_MRST: assert property (s_cmd(`LSCI_CMD_RESET) |=>
    r.tx == lsci_pkg::TX_IDLE && !r.held && !r.integ && r.prst == 5'h00) // [RQ3]
    else $error("main reset left state active");
  AST_ABORT: assert property (s_cmd(`LSCI_CMD_ABORT) |=>
    r.tx == lsci_pkg::TX_IDLE && !r.held && !r.integ) // [RQ10]
    else $error("abort left state active");
  AST_START: assert property (rise && r.prst == 5'h01 && !exec |=> r.integ) // [RQ5]
    else $error("integration did not begin after pixel reset");
  AST_PRST: assert property (s_cmd(`LSCI_CMD_RDHNS) |=>
    r.prst == `LSCI_PRST_CLKS && r.held && r.pix_mode) // [RQ12]
    else $error("combined restart command mishandled");
  AST_SAMPLE: assert property (s_cmd(`LSCI_CMD_SAMPLE) |=> r.held && !r.integ) // [RQ6]
    else $error("sample did not hold");
  AST_READ: assert property (s_cmd(`LSCI_CMD_RDHOLD) |=>
    r.tx == lsci_pkg::TX_WAIT && r.wcnt == `LSCI_PIX_DELAY && r.held) // [RQ9]
    else $error("readout latency not loaded");
  AST_FRAME: assert property (do_load |=> !r.sout && r.tx_sh[9] && !r.tx_sh[0]) // [RQ7]
    else $error("frame bits wrong");
  AST_ORDER: assert property (do_load && r.pix_mode && r.pix_idx != `LSCI_PIX_LAST
    |=> r.pix_idx == $past(r.pix_idx) + 7'h01) // [RQ8]
    else $error("pixel order broken");
  AST_REGRD: assert property (exec && rx_byte[7:5] == `LSCI_OP_READ |=>
    r.wcnt == `LSCI_REG_DELAY && !r.pix_mode) // [RQ14]
    else $error("register read latency wrong");
  AST_WRITE: assert property (byte_done && r.wr_pend && r.wr_addr == `LSCI_ADR_MODE
    |=> r.mode == $past(rx_byte) && !r.wr_pend) // [RQ13]
    else $error("register write lost");

endmodule // lsci_top

// ==== sim/lsci_ctrl.sv ====
// Controller model that drives the serial clock and data pins.
// Assumes a free-running i_mclk; one serial clock spans 19 of its cycles.
`timescale 1ns/10ps

module lsci_ctrl (
  input  wire logic i_mclk,
  output logic      o_sclk,
  output logic      o_serial_in
);
  // ------------------------------------------------------------
  // Serial clocking
  // ------------------------------------------------------------
  initial begin
    o_sclk = 1'b0;
    o_serial_in = 1'b1;
  end

  task automatic tick(input logic b);
    @(posedge i_mclk);
    o_sclk <= 1'b0;
    o_serial_in <= b;
    repeat (9) @(posedge i_mclk);
    o_sclk <= 1'b1;
    repeat (9) @(posedge i_mclk);
  endtask

  task automatic idle(input int n);
    repeat (n) tick(1'b1);
  endtask

  task automatic send(input logic [7:0] b);
    tick(1'b0);
    for (int i = 0; i < 8; i++) tick(b[i]);
    idle(5);
  endtask

  task automatic brk();
    repeat (30) tick(1'b0);
    idle(10);
  endtask
endmodule // lsci_ctrl

// ==== sim/lsci_top_tb.sv ====
// Self-checking bench of the sensor command interpreter.
// Assumes lsci_ctrl drives the pins; output words are decoded at sclk rise.
`timescale 1ns/10ps
`include "lsci_cfg.svh"

module lsci_top_tb;
  logic        mclk;
  logic        reset;
  logic        sclk;
  logic        serial_in;
  logic [7:0]  pixel_code;
  logic        sout;
  logic        integ;
  logic        held;
  logic        prst;
  logic [6:0]  pidx;
  logic [23:0] offs;
  logic [14:0] gains;
  logic        sleep;
  int          mismatches;
  int          compares;
  int          rises;
  int          rise0;
  int          bitn;
  int          r;
  logic [31:0] seed;
  logic [7:0]  sh;
  logic [7:0]  pix [128];
  logic [7:0]  regs [32];
  int          exp_t [$];
  logic [7:0]  exp_d [$];
  int          adr [8] = '{0, 1, 2, 3, 4, 5, 7, 31};

  lsci_top lsci_top_inst (.i_mclk(mclk), .i_reset(reset), .i_sclk(sclk), .i_serial_in(serial_in),
    .i_pixel_code(pixel_code), .o_serial_out(sout), .o_integrating(integ), .o_held_valid(held),
    .o_pixel_reset(prst), .o_pixel_idx(pidx), .o_offsets(offs), .o_gains(gains), .o_sleep(sleep));
  lsci_ctrl lsci_ctrl_inst (.i_mclk(mclk), .o_sclk(sclk), .o_serial_in(serial_in));

  always #2.5 mclk = ~mclk;
  always @(posedge mclk) pixel_code <= pix[pidx];

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic flags(input logic [2:0] e);
    #1;
    chk("flags", {integ, held, prst}, e);
  endtask

  task automatic want(input int t, input logic [7:0] d);
    exp_t.push_back(t);
    exp_d.push_back(d);
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Output word monitor
  // ------------------------------------------------------------
  always @(posedge sclk) begin
    rises = rises + 1;
    if (bitn == 0) begin
      if (sout === 1'b0) begin
        bitn = 1;
        rise0 = rises;
      end else if (sout !== 1'b1) chk("idle", sout, 1);
    end else if (bitn < 9) begin
      sh[bitn-1] = sout;
      bitn++;
    end else begin
      bitn = 0;
      chk("stop", sout, 1);
      if (exp_t.size() == 0) chk("extra_word", 1, 0);
      else begin
        chk("start_time", rise0, exp_t.pop_front());
        chk("word", sh, exp_d.pop_front());
      end
    end
  end

  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    pixel_code = 8'h00;
    seed = 32'h602dafdd;
    for (int i = 0; i < 128; i++) begin
      seed = lfsr(seed);
      pix[i] = seed[7:0];
    end
    foreach (regs[i]) regs[i] = 8'h00;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    lsci_ctrl_inst.idle(10);
    lsci_ctrl_inst.brk();
    lsci_ctrl_inst.send(`LSCI_CMD_RESET);
    lsci_ctrl_inst.idle(30);
    flags(3'b000);
    $display("test init done");
    for (int a = 0; a < 6; a++) begin
      seed = lfsr(seed);
      regs[a] = a[0] ? {3'h0, seed[4:0]} : seed[7:0];
      lsci_ctrl_inst.send({`LSCI_OP_WRITE, a[4:0]});
      lsci_ctrl_inst.send(seed[7:0]);
    end
    lsci_ctrl_inst.send(8'h47);
    lsci_ctrl_inst.send(8'haa);
    lsci_ctrl_inst.send(8'h5f);
    lsci_ctrl_inst.send(8'h10);
    regs[31] = 8'h10;
    #1;
    chk("offsets", offs, {regs[4], regs[2], regs[0]});
    chk("gains", gains, {regs[5][4:0], regs[3][4:0], regs[1][4:0]});
    chk("sleep", sleep, 1);
    foreach (adr[i]) begin
      lsci_ctrl_inst.send({`LSCI_OP_READ, adr[i][4:0]});
      want(rises - 1, regs[adr[i]]);
      lsci_ctrl_inst.idle(8);
    end
    lsci_ctrl_inst.send(8'h5f);
    lsci_ctrl_inst.send(8'h00);
    #1;
    chk("sleep", sleep, 0);
    $display("test registers done");
    lsci_ctrl_inst.send(`LSCI_CMD_START);
    flags(3'b001);
    lsci_ctrl_inst.idle(16);
    flags(3'b001);
    lsci_ctrl_inst.idle(1);
    flags(3'b100);
    lsci_ctrl_inst.send(`LSCI_CMD_SAMPLE);
    flags(3'b010);
    lsci_ctrl_inst.send(`LSCI_CMD_READ);
    r = rises - 5;
    for (int k = 0; k < 102; k++) want(r + 44 + 10 * k, pix[k]);
    lsci_ctrl_inst.send(`LSCI_CMD_START);
    lsci_ctrl_inst.idle(22);
    #1;
    chk("integ", integ, 1);
    lsci_ctrl_inst.idle(1040);
    chk("left", exp_t.size(), 0);
    $display("test readout done");
    lsci_ctrl_inst.send(`LSCI_CMD_ABORT);
    flags(3'b000);
    lsci_ctrl_inst.send(8'h40);
    lsci_ctrl_inst.brk();
    // The first nine break zeros still form a data byte of zero, which
    // completes the pending write before the break itself is counted.
    regs[0] = 8'h00;
    lsci_ctrl_inst.send(`LSCI_CMD_SAMPLE);
    lsci_ctrl_inst.send(8'hff);
    flags(3'b010);
    chk("offsets", offs, {regs[4], regs[2], regs[0]});
    $display("test break done");
    for (int j = 0; j < 2; j++) begin
      lsci_ctrl_inst.send(j ? `LSCI_CMD_RDHOLD : `LSCI_CMD_RDHNS);
      want(rises + 39, pix[0]);
      flags(j ? 3'b010 : 3'b011);
      lsci_ctrl_inst.idle(39);
      lsci_ctrl_inst.send(j ? `LSCI_CMD_RESET : `LSCI_CMD_ABORT);
      flags(3'b000);
      lsci_ctrl_inst.idle(30);
      chk("left", exp_t.size(), 0);
    end
    $display("test abort done");
    print_verdict();
  end

  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    print_verdict();
  end
endmodule // lsci_top_tb
